/* File: rtl/ata_sf_pkg.sv */
package ata_sf_pkg;
    // task-file register addresses
    localparam logic [8:0] ADR_ERR_FEAT = 9'h1f1;
    localparam logic [8:0] ADR_SCOUNT = 9'h1f2;
    localparam logic [8:0] ADR_SNUM = 9'h1f3;
    localparam logic [8:0] ADR_CYL_LO = 9'h1f4;
    localparam logic [8:0] ADR_CYL_HI = 9'h1f5;
    localparam logic [8:0] ADR_DRV_HEAD = 9'h1f6;
    localparam logic [8:0] ADR_CMD_STAT = 9'h1f7;
    // command codes
    localparam logic [7:0] CMD_IDENT_DMA = 8'hee;
    localparam logic [7:0] CMD_SET_FEAT = 8'hef;
    // feature codes
    localparam logic [7:0] FC_WC_ON = 8'h02;
    localparam logic [7:0] FC_XFER = 8'h03;
    localparam logic [7:0] FC_APM_ON = 8'h05;
    localparam logic [7:0] FC_RC_OFF = 8'h55;
    localparam logic [7:0] FC_KEEP = 8'h66;
    localparam logic [7:0] FC_WC_OFF = 8'h82;
    localparam logic [7:0] FC_APM_OFF = 8'h85;
    localparam logic [7:0] FC_RC_ON = 8'haa;
    localparam logic [7:0] FC_ECC4 = 8'hbb;
    localparam logic [7:0] FC_REVERT = 8'hcc;
    // transfer type field values (upper five bits of sector count) and mode limits (lower three)
    localparam logic [4:0] XT_PIO_DEF = 5'h00;
    localparam logic [4:0] XT_PIO_FC = 5'h01;
    localparam logic [4:0] XT_MDMA = 5'h04;
    localparam logic [4:0] XT_UDMA = 5'h08;
    localparam logic [2:0] XM_PIO_MAX = 3'h4;
    localparam logic [2:0] XM_MDMA_MAX = 3'h2;
    localparam logic [2:0] XM_UDMA_MAX = 3'h4;
    // status, error and device bit positions, and the transfer reset value
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_ERR = 0;
    localparam int ER_ABORT = 2;
    localparam int DH_DEV = 4;
    localparam logic [7:0] XFER_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_IDENT = 2'b10
    } cmd_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } tf_req_s;

    typedef struct packed {
        logic wcache;
        logic rcache;
        logic apm;
        logic revert;
        logic ecc4;
        logic [7:0] xfer;
    } mode_s;
endpackage : ata_sf_pkg

/* File: rtl/ata_set_features_decoder.sv */
// Overview of operation
// - command code 0xee selects identify-device-DMA
// - identify-DMA without DMA acts exactly like plain identify-device; the code always sets ident_dma on 0xee, whatever mode.xfer holds
// - command code 0xef selects set-features using feature_select code
// - set-features raises busy, stores parameters, clears busy, raises irq
// - unsupported feature code completes with aborted-command error
// - feature 0x03 takes transfer mode from sector_count
// - pio 4, sw dma 2, multiword dma always stay supported
// - 0x02 sets write cache enable, 0x82 clears it
// - 0xaa sets read cache enable, 0x55 clears it
// - 0x05 enables power management, 0x85 disables it
// - 0x66 stops revert on soft reset, 0xcc restores it
// - 0xbb selects 4-byte ecc for long read and write
// - host writes command at 1f7, device bit at 1f6
// - completion shows status 1f7, device bit 1f6, error 1f1
// - sector count: upper five bits type, lower three mode
// - only 0x00, 0x08-0x0c, 0x20-0x22, 0x40-0x44 accepted
// - reset defaults equal codes above 0xaa, write cache excepted
module ata_set_features_decoder
    import ata_sf_pkg::*;
#(
    parameter logic DRIVE_UNIT = 1'b0,
    parameter logic WCACHE_DEFAULT = 1'b1,
    parameter logic RCACHE_DEFAULT = 1'b1,
    parameter logic APM_DEFAULT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire tf_req_s tf_req,
    output logic [7:0] tf_rdata,
    output logic intrq,
    input wire logic soft_reset,
    output logic ident_req,
    output logic ident_dma,
    input wire logic ident_done,
    output mode_s mode,
    output logic pio4_ok,
    output logic sdma2_ok,
    output logic mdma_ok
);
    localparam mode_s MODE_DEFAULT = '{wcache: WCACHE_DEFAULT,
        rcache: RCACHE_DEFAULT, apm: APM_DEFAULT, revert: 1'b1,
        ecc4: 1'b1, xfer: XFER_RESET};

    cmd_state_e state_reg;
    logic [7:0] feat_reg;
    logic [7:0] scount_reg;
    logic [7:0] snum_reg;
    logic [7:0] cyl_lo_reg;
    logic [7:0] cyl_hi_reg;
    logic [7:0] dh_reg;
    logic busy;
    logic err_reg;
    logic abort_reg;
    logic cmd_wr;
    logic cmd_hit;
    logic feat_ok;
    logic xfer_ok;
    mode_s mode_next;

    assign busy = (state_reg != ST_IDLE);
    assign cmd_wr = tf_req.wr && (tf_req.addr == ADR_CMD_STAT) && !busy;
    assign cmd_hit = cmd_wr && (dh_reg[DH_DEV] == DRIVE_UNIT);

    // ------------------------------------------------------------------
    // task-file writes
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            feat_reg <= 8'h00;
            scount_reg <= 8'h00;
            snum_reg <= 8'h00;
            cyl_lo_reg <= 8'h00;
            cyl_hi_reg <= 8'h00;
            dh_reg <= 8'h00;
        end else if (tf_req.wr && !busy) begin
            case (tf_req.addr)
                ADR_ERR_FEAT: feat_reg <= tf_req.wdata;
                ADR_SCOUNT: scount_reg <= tf_req.wdata;
                ADR_SNUM: snum_reg <= tf_req.wdata;
                ADR_CYL_LO: cyl_lo_reg <= tf_req.wdata;
                ADR_CYL_HI: cyl_hi_reg <= tf_req.wdata;
                ADR_DRV_HEAD: dh_reg <= tf_req.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // feature decode
    // ------------------------------------------------------------------
    always_comb begin
        logic [4:0] xt;
        logic [2:0] xm;
        xt = scount_reg[7:3];
        xm = scount_reg[2:0];
        case (xt)
            XT_PIO_DEF: xfer_ok = (xm == 3'h0);
            XT_PIO_FC: xfer_ok = (xm <= XM_PIO_MAX);
            XT_MDMA: xfer_ok = (xm <= XM_MDMA_MAX);
            XT_UDMA: xfer_ok = (xm <= XM_UDMA_MAX);
            default: xfer_ok = 1'b0;
        endcase
        mode_next = mode;
        feat_ok = 1'b1;
        case (feat_reg)
            FC_WC_ON: mode_next.wcache = 1'b1;
            FC_WC_OFF: mode_next.wcache = 1'b0;
            FC_RC_ON: mode_next.rcache = 1'b1;
            FC_RC_OFF: mode_next.rcache = 1'b0;
            FC_APM_ON: mode_next.apm = 1'b1;
            FC_APM_OFF: mode_next.apm = 1'b0;
            FC_KEEP: mode_next.revert = 1'b0;
            FC_REVERT: mode_next.revert = 1'b1;
            FC_ECC4: mode_next.ecc4 = 1'b1;
            FC_XFER: begin
                feat_ok = xfer_ok;
                if (xfer_ok) begin
                    mode_next.xfer = scount_reg;
                end
            end
            8'h04, 8'h33, 8'h54, 8'h77, 8'h81,
            8'h84, 8'h88, 8'h99, 8'hab: ;
            default: feat_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_hit && tf_req.wdata == CMD_SET_FEAT) begin
                        state_reg <= ST_EXEC;
                    end else if (cmd_hit && tf_req.wdata == CMD_IDENT_DMA) begin
                        state_reg <= ST_IDENT;
                    end else if (cmd_hit) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: state_reg <= ST_IDLE;
                ST_IDENT: begin
                    if (ident_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // latched command code for the execute step
    logic is_setf_reg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            is_setf_reg <= 1'b0;
        end else if (cmd_hit) begin
            is_setf_reg <= (tf_req.wdata == CMD_SET_FEAT);
        end
    end

    // ------------------------------------------------------------------
    // mode flags
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_DEFAULT;
        end else if (state_reg == ST_EXEC && is_setf_reg && feat_ok) begin
            mode <= mode_next;
        end else if (soft_reset && mode.revert) begin
            mode <= '{wcache: mode.wcache, rcache: RCACHE_DEFAULT,
                apm: APM_DEFAULT, revert: 1'b1, ecc4: 1'b1,
                xfer: XFER_RESET};
        end
    end

    // transfer modes the drive can always run regardless of setting
    assign pio4_ok = 1'b1;
    assign sdma2_ok = 1'b1;
    assign mdma_ok = 1'b1;

    // ------------------------------------------------------------------
    // completion: error, interrupt, identify hand-off
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else if (cmd_hit) begin
            err_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else if (state_reg == ST_EXEC) begin
            err_reg <= !(is_setf_reg && feat_ok);
            abort_reg <= !(is_setf_reg && feat_ok);
        end
    end

    logic done_evt;
    assign done_evt = (state_reg == ST_EXEC)
        || (state_reg == ST_IDENT && ident_done);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intrq <= 1'b0;
        end else if (done_evt) begin
            intrq <= 1'b1;
        end else if (cmd_wr
                || (tf_req.rd && tf_req.addr == ADR_CMD_STAT)) begin
            intrq <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ident_req <= 1'b0;
            ident_dma <= 1'b0;
        end else begin
            ident_req <= cmd_hit && (tf_req.wdata == CMD_IDENT_DMA);
            if (cmd_hit && tf_req.wdata == CMD_IDENT_DMA) begin
                ident_dma <= 1'b1;
            end else if (state_reg == ST_IDLE) begin
                ident_dma <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // task-file reads
    // ------------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] err_byte;
    always_comb begin
        err_byte = 8'h00;
        err_byte[ER_ABORT] = abort_reg;
        status = 8'h00;
        status[ST_BUSY] = busy;
        status[ST_READY] = !busy;
        status[ST_ERR] = err_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tf_rdata <= 8'h00;
        end else if (tf_req.rd) begin
            case (tf_req.addr)
                ADR_ERR_FEAT: tf_rdata <= err_byte;
                ADR_SCOUNT: tf_rdata <= scount_reg;
                ADR_SNUM: tf_rdata <= snum_reg;
                ADR_CYL_LO: tf_rdata <= cyl_lo_reg;
                ADR_CYL_HI: tf_rdata <= cyl_hi_reg;
                ADR_DRV_HEAD: tf_rdata <= dh_reg;
                ADR_CMD_STAT: tf_rdata <= status;
                default: tf_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic setf_go;
    assign setf_go = cmd_hit && tf_req.wdata == CMD_SET_FEAT;

    property p_setf_busy;
        setf_go |=> busy ##1 (!busy && intrq);
    endproperty
    a_setf_busy: assert property (p_setf_busy)
        else $error("set-features busy/irq sequence wrong");

    property p_wc_on;
        setf_go && feat_reg == FC_WC_ON |-> ##2 mode.wcache;
    endproperty
    a_wc_on: assert property (p_wc_on)
        else $error("write cache not enabled");

    property p_wc_off;
        setf_go && feat_reg == FC_WC_OFF |-> ##2 !mode.wcache;
    endproperty
    a_wc_off: assert property (p_wc_off)
        else $error("write cache not disabled");

    property p_rc;
        setf_go && feat_reg == FC_RC_OFF |-> ##2 !mode.rcache;
    endproperty
    a_rc: assert property (p_rc)
        else $error("read cache not disabled");

    property p_apm;
        setf_go && feat_reg == FC_APM_OFF |-> ##2 !mode.apm;
    endproperty
    a_apm: assert property (p_apm)
        else $error("power management not disabled");

    property p_abort;
        setf_go && !feat_ok |-> ##2 abort_reg && err_reg;
    endproperty
    a_abort: assert property (p_abort)
        else $error("bad feature not aborted");

    property p_xfer_bad;
        setf_go && feat_reg == FC_XFER && !xfer_ok
            |-> ##2 abort_reg && $stable(mode.xfer);
    endproperty
    a_xfer_bad: assert property (p_xfer_bad)
        else $error("bad transfer mode accepted");

    property p_xfer_ok;
        setf_go && feat_reg == FC_XFER && xfer_ok
            |-> ##2 mode.xfer == $past(scount_reg, 2) && !err_reg;
    endproperty
    a_xfer_ok: assert property (p_xfer_ok)
        else $error("transfer mode not taken");

    property p_ident;
        cmd_hit && tf_req.wdata == CMD_IDENT_DMA |=> ident_req && busy;
    endproperty
    a_ident: assert property (p_ident)
        else $error("identify not started");

    c_setf_ok: cover property (setf_go && feat_ok ##2 !err_reg);
    c_setf_abort: cover property (setf_go && !feat_ok ##2 err_reg);
    c_ident: cover property (ident_req ##[1:20] !busy);
endmodule : ata_set_features_decoder

/* File: dv/ata_host_model.sv */
// ----------------------------------------------------------------
// host side of the task-file bus
// ----------------------------------------------------------------
module ata_host_model
    import ata_sf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] tf_rdata,
    output tf_req_s tf_req
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tf_req = '0;
    end

    // one write strobe per byte; the bus is scrambled once released
    task automatic write(input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        tf_req.wr = 1'b1;
        tf_req.addr = a;
        tf_req.wdata = d;
        @(posedge sys_clk);
        #1;
        tf_req.wr = 1'b0;
        tf_req.addr = ~a;
        tf_req.wdata = ~d;
    endtask : write

    // read data is registered, so it is taken one edge after the strobe
    task automatic read(input logic [8:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        tf_req.rd = 1'b1;
        tf_req.addr = a;
        @(posedge sys_clk);
        #1;
        d = tf_rdata;
        tf_req.rd = 1'b0;
        tf_req.addr = ~a;
    endtask : read
endmodule : ata_host_model

/* File: dv/ata_set_features_decoder_test.sv */
module ata_set_features_decoder_test;
    import ata_sf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, rst_n, soft_reset, ident_done;
    logic intrq, ident_req, ident_dma, pio4_ok, sdma2_ok, mdma_ok;
    logic [7:0] tf_rdata, rd8;
    tf_req_s tf_req;
    mode_s mode, exp;
    int n_errors = 0;
    int tests_run = 0;
    logic [7:0] codes[20] = '{8'h02, 8'h82, 8'haa, 8'h55, 8'h05, 8'h85,
        8'hbb, 8'h66, 8'hcc, 8'h04, 8'h33, 8'h54, 8'h77, 8'h81, 8'h84,
        8'h88, 8'h99, 8'hab, 8'h10, 8'hff};
    logic [7:0] scs[13] = '{8'h00, 8'h08, 8'h0c, 8'h20, 8'h22, 8'h40,
        8'h44, 8'h01, 8'h0d, 8'h1f, 8'h23, 8'h45, 8'h80};

    ata_set_features_decoder ata_set_features_decoder_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .tf_req(tf_req), .tf_rdata(tf_rdata), .intrq(intrq),
        .soft_reset(soft_reset), .ident_req(ident_req),
        .ident_dma(ident_dma), .ident_done(ident_done), .mode(mode),
        .pio4_ok(pio4_ok), .sdma2_ok(sdma2_ok), .mdma_ok(mdma_ok));
    ata_host_model ata_host_model_i (.sys_clk(sys_clk),
        .tf_rdata(tf_rdata), .tf_req(tf_req));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] got, exp_v, input string msg);
        tests_run++;
        if (got !== exp_v) begin
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp_v);
            n_errors++;
        end
    endtask : check

    // host waits for completion rather than writing while busy
    task automatic wait_irq();
        for (int i = 0; i < 10 && intrq !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (intrq !== 1'b1) begin
            $display("MISMATCH %0t no completion interrupt", $time);
            n_errors++;
            summarize();
        end
    endtask : wait_irq

    function automatic logic sc_ok(input logic [7:0] sc);
        return sc == 8'h00 || (sc >= 8'h08 && sc <= 8'h0c) ||
            (sc >= 8'h20 && sc <= 8'h22) || (sc >= 8'h40 && sc <= 8'h44);
    endfunction : sc_ok

    task automatic sf(input logic [7:0] fc, input logic [7:0] sc);
        logic ab;
        ab = 1'b0;
        case (fc)
            FC_WC_ON: exp.wcache = 1'b1;
            FC_WC_OFF: exp.wcache = 1'b0;
            FC_RC_ON: exp.rcache = 1'b1;
            FC_RC_OFF: exp.rcache = 1'b0;
            FC_APM_ON: exp.apm = 1'b1;
            FC_APM_OFF: exp.apm = 1'b0;
            FC_KEEP: exp.revert = 1'b0;
            FC_REVERT: exp.revert = 1'b1;
            FC_ECC4: exp.ecc4 = 1'b1;
            FC_XFER: begin
                if (sc_ok(sc)) exp.xfer = sc;
                else ab = 1'b1;
            end
            8'h04, 8'h33, 8'h54, 8'h77, 8'h81, 8'h84, 8'h88, 8'h99, 8'hab: ;
            default: ab = 1'b1;
        endcase
        ata_host_model_i.write(ADR_SCOUNT, sc);
        ata_host_model_i.write(ADR_ERR_FEAT, fc);
        ata_host_model_i.write(ADR_DRV_HEAD, 8'h00);
        ata_host_model_i.write(ADR_CMD_STAT, CMD_SET_FEAT);
        check(intrq, 1'b0, "irq early");
        wait_irq();
        check(mode, exp, "mode after feature");
        check(mode, exp, "mode after no-op or abort");
        ata_host_model_i.read(ADR_CMD_STAT, rd8);
        check({rd8[ST_BUSY], rd8[ST_ERR]}, {1'b0, ab}, "status");
        check(intrq, 1'b0, "irq after status read");
        ata_host_model_i.read(ADR_ERR_FEAT, rd8);
        check(rd8[ER_ABORT], ab, "abort bit");
    endtask : sf

    task automatic pulse_soft_reset();
        @(posedge sys_clk);
        #1;
        soft_reset = 1'b1;
        @(posedge sys_clk);
        #1;
        soft_reset = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : pulse_soft_reset

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        soft_reset = 1'b0;
        ident_done = 1'b0;
        exp = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
        repeat (12) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        check(mode, exp, "reset modes");
        check({pio4_ok, sdma2_ok, mdma_ok}, 3'b111, "modes kept");
        for (int a = 3; a <= 5; a++) begin
            ata_host_model_i.write(9'h1f0 + 9'(a), 8'(8'h5a ^ a));
            ata_host_model_i.read(9'h1f0 + 9'(a), rd8);
            check(rd8, 8'(8'h5a ^ a), "task-file readback");
        end
        foreach (codes[i]) sf(codes[i], 8'h00);
        foreach (scs[i]) sf(FC_XFER, scs[i]);
        check({pio4_ok, sdma2_ok, mdma_ok}, 3'b111, "modes kept");
        // identify variant: engine finish is reported by ident_done
        ata_host_model_i.write(ADR_CMD_STAT, CMD_IDENT_DMA);
        for (int i = 0; i < 4 && ident_req !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check({ident_req, ident_dma}, 2'b11, "identify start");
        repeat (3) @(posedge sys_clk);
        #1;
        check(intrq, 1'b0, "irq before engine done");
        ident_done = 1'b1;
        @(posedge sys_clk);
        #1;
        ident_done = 1'b0;
        wait_irq();
        ata_host_model_i.read(ADR_CMD_STAT, rd8);
        check({rd8[ST_BUSY], rd8[ST_ERR]}, 2'b00, "identify status");
        ata_host_model_i.read(ADR_DRV_HEAD, rd8);
        check(rd8[DH_DEV], 1'b0, "device bit readable");
        // command for the other unit must be ignored
        ata_host_model_i.write(ADR_ERR_FEAT, FC_RC_ON);
        ata_host_model_i.write(ADR_DRV_HEAD, 8'h10);
        ata_host_model_i.write(ADR_CMD_STAT, CMD_SET_FEAT);
        repeat (5) @(posedge sys_clk);
        #1;
        check({intrq, ident_dma, mode}, {2'b00, exp}, "other unit");
        // unknown command code is aborted without touching any mode
        ata_host_model_i.write(ADR_DRV_HEAD, 8'h00);
        ata_host_model_i.write(ADR_CMD_STAT, 8'h5c);
        wait_irq();
        ata_host_model_i.read(ADR_CMD_STAT, rd8);
        check({rd8[ST_BUSY], rd8[ST_ERR]}, 2'b01, "unknown command");
        check(mode, exp, "mode after unknown command");
        // soft reset with and without reverting
        sf(FC_WC_OFF, 8'h00);
        sf(FC_RC_OFF, 8'h00);
        sf(FC_KEEP, 8'h00);
        pulse_soft_reset();
        check(mode, exp, "kept over soft reset");
        sf(FC_REVERT, 8'h00);
        pulse_soft_reset();
        exp = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
        check(mode, exp, "reverted defaults");
        summarize();
    end
endmodule : ata_set_features_decoder_test
